// file: pkg/rtc_control_defs.vh
`ifndef RTC_CONTROL_DEFS_VH
`define RTC_CONTROL_DEFS_VH
// Register byte addresses
`define ADDR_CONTROL     8'h04
`define ADDR_CAPTURE     8'h08
`define ADDR_ALARM       8'h0c
`define ADDR_INT_STATUS  8'h10
`define ADDR_INT_ENABLE  8'h14
`define ADDR_INT_CLEAR   8'h18
`define ADDR_COUNT       8'h1c
// Control register fields
`define BIT_OSC_EN       7
`define BIT_MCLK_EN      6
`define BIT_OSC_FAIL     5
`define BIT_RUN          4
`define BIT_ALARM_EN     3
`define BIT_ALARM        2
`define BIT_SET          1
`define BIT_CAPTURE      0
// Interrupt status fields
`define IRQ_ALARM        0
`define IRQ_FAIL         1
`define IRQ_SET_DONE     2
`define IRQ_CAP_DONE     3
`define IRQ_WIDTH        4
// Reset values
`define CONTROL_RESET    8'h00
`define ZERO32           32'h00000000
// Missing clock timeout in ns
`define MCLK_TIMEOUT_NS  100000
`define CLK_PERIOD_NS    100
`endif

// file: src/rtc_sync2.v
module rtc_sync2 (
  input  wire CLK_SYS,
  input  wire RST,
  input  wire d,
  output reg  q
);
  reg meta_q;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: src/rtc_control.v
// Function
// - The oscillator enable bit turns the timer oscillator and its bias on when set, off when clear.
// - The fail flag is set by hardware whenever the missing-clock detector times out.
// - The run bit lets the 32-bit count advance; when clear the count holds except when a set loads it or a pending auto-reset zeroes it.
// - Reading the alarm bit returns the live alarm event flag.
// - Writing one to the set bit starts a set; hardware clears the bit when done.
// - Clearing the alarm enable also clears the alarm event flag.
// - With auto-reset, the count goes to zero one oscillator cycle after alarm deasserts.
// - A set loads the 32-bit capture value into the count.
// - Writing one to the capture bit snapshots the count; hardware clears the bit after.
`include "rtc_control_defs.vh"
module rtc_control #(
  parameter MCLK_TIMEOUT_CYC = `MCLK_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HSEL,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        OSC_CLK_IN,
  output reg         OSC_ENABLE,
  output reg         IRQ
);
  reg         osc_en_q;
  reg         mclk_en_q;
  reg         fail_q;
  reg         run_q;
  reg         alarm_en_q;
  reg         autoreset_q;
  reg         set_q;
  reg         cap_q;
  reg         alarm_q;
  reg         ar_pend_q;
  reg  [31:0] count_q;
  reg  [31:0] capture_q;
  reg  [31:0] alarm_val_q;
  reg  [`IRQ_WIDTH-1:0] stat_q;
  reg  [`IRQ_WIDTH-1:0] ien_q;
  reg  [7:0]  wr_addr_q;
  reg         wr_pend_q;
  reg  [31:0] mclk_cnt_q;
  reg         osc_prev_q;
  wire        osc_s;
  wire        osc_rise;
  wire        mclk_timeout;
  wire        alarm_hit;
  wire        wr_ctl;
  wire        ctl_set_w;
  wire        ctl_cap_w;
  reg  [`IRQ_WIDTH-1:0] ev;
  reg  [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator input, synchronised before use
  // A third flop (osc_prev_q) forms the edge; the raw pin is never read
  rtc_sync2 u_sync (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .d       (OSC_CLK_IN),
    .q       (osc_s)
  );

  assign osc_rise = osc_s & ~osc_prev_q & osc_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  // HSIZE is ignored: only whole-word accesses are supported
  // Address bits above 7:0 are not decoded, so the map repeats
  wire addr_ok = HSEL & HREADY & HTRANS[1];
  always @* begin
    case (HADDR[7:0])
      `ADDR_CONTROL:    rd = {24'h000000, osc_en_q, mclk_en_q, fail_q, run_q,
                              alarm_en_q, alarm_q, set_q, cap_q};
      `ADDR_CAPTURE:    rd = capture_q;
      `ADDR_ALARM:      rd = alarm_val_q;
      `ADDR_INT_STATUS: rd = {28'h0000000, stat_q};
      `ADDR_INT_ENABLE: rd = {28'h0000000, ien_q};
      `ADDR_COUNT:      rd = count_q;
      // The clear register is write-only and reads as zero
      default:          rd = `ZERO32;
    endcase
  end

  // Writes land at the end of the data phase, while HWDATA still stands
  assign wr_ctl    = wr_pend_q & (wr_addr_q == `ADDR_CONTROL);
  assign ctl_set_w = wr_ctl & HWDATA[`BIT_SET];
  assign ctl_cap_w = wr_ctl & HWDATA[`BIT_CAPTURE];

  always @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      HRDATA    <= `ZERO32;
      // Constant flops: the slave never waits and never reports an error
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok & HWRITE;
      wr_addr_q <= HADDR[7:0];
      if (addr_ok & ~HWRITE)
        HRDATA <= rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Missing clock detector: no edge of the oscillator for the timeout
  // The counter saturates, so the timeout stays high until the pin moves or an enable drops
  assign mclk_timeout = mclk_en_q & osc_en_q & (mclk_cnt_q >= MCLK_TIMEOUT_CYC);

  always @(posedge CLK_SYS) begin
    if (RST) begin
      mclk_cnt_q <= `ZERO32;
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
      if (~mclk_en_q | ~osc_en_q | (osc_s != osc_prev_q))
        mclk_cnt_q <= `ZERO32;
      else if (~mclk_timeout)
        mclk_cnt_q <= mclk_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and timer
  // Equality match only; with auto-reset the count peaks two above the alarm value
  assign alarm_hit = alarm_en_q & (count_q == alarm_val_q);

  always @(posedge CLK_SYS) begin
    if (RST) begin
      osc_en_q    <= 1'b0;
      mclk_en_q   <= 1'b0;
      fail_q      <= 1'b0;
      run_q       <= 1'b0;
      alarm_en_q  <= 1'b0;
      autoreset_q <= 1'b0;
      set_q       <= 1'b0;
      cap_q       <= 1'b0;
      alarm_q     <= 1'b0;
      ar_pend_q   <= 1'b0;
      count_q     <= `ZERO32;
      capture_q   <= `ZERO32;
      alarm_val_q <= `ZERO32;
      OSC_ENABLE  <= 1'b0;
    end else begin
      OSC_ENABLE <= osc_en_q;
      if (wr_ctl) begin
        osc_en_q    <= HWDATA[`BIT_OSC_EN];
        mclk_en_q   <= HWDATA[`BIT_MCLK_EN];
        run_q       <= HWDATA[`BIT_RUN];
        alarm_en_q  <= HWDATA[`BIT_ALARM_EN];
        autoreset_q <= HWDATA[`BIT_ALARM];
      end
      // Set beats software's clear so a timeout is never lost
      // Writing zero to the flag clears it; writing one leaves it as it is
      if (mclk_timeout)
        fail_q <= 1'b1;
      else if (wr_ctl & ~HWDATA[`BIT_OSC_FAIL])
        fail_q <= 1'b0;
      if (wr_pend_q & (wr_addr_q == `ADDR_CAPTURE))
        capture_q <= HWDATA;
      if (wr_pend_q & (wr_addr_q == `ADDR_ALARM))
        alarm_val_q <= HWDATA;
      if (ctl_set_w)
        set_q <= 1'b1;
      if (ctl_cap_w)
        cap_q <= 1'b1;
      // Handshakes complete on the next rising oscillator edge, as the real timer would
      // With the oscillator off no edge comes, so set and capture stay pending
      if (osc_rise) begin
        alarm_q <= alarm_hit;
        if (set_q) begin
          count_q <= capture_q;
          set_q   <= 1'b0;
        end else if (ar_pend_q & ~alarm_q) begin
          count_q <= `ZERO32;
        end else if (run_q) begin
          count_q <= count_q + 32'h00000001;
        end
        ar_pend_q <= alarm_q ? autoreset_q : 1'b0;
        if (cap_q) begin
          capture_q <= count_q;
          cap_q     <= 1'b0;
        end
      end
      if ((wr_ctl & ~HWDATA[`BIT_ALARM_EN]) | ~alarm_en_q)
        alarm_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over clear
  // IRQ lags status by a cycle so that it leaves the block from a flop
  always @* begin
    ev = {`IRQ_WIDTH{1'b0}};
    ev[`IRQ_ALARM]    = osc_rise & alarm_hit;
    ev[`IRQ_FAIL]     = mclk_timeout & ~fail_q;
    ev[`IRQ_SET_DONE] = osc_rise & set_q;
    ev[`IRQ_CAP_DONE] = osc_rise & cap_q;
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      stat_q <= {`IRQ_WIDTH{1'b0}};
      ien_q  <= {`IRQ_WIDTH{1'b0}};
      IRQ    <= 1'b0;
    end else begin
      if (wr_pend_q & (wr_addr_q == `ADDR_INT_ENABLE))
        ien_q <= HWDATA[`IRQ_WIDTH-1:0];
      if (wr_pend_q & (wr_addr_q == `ADDR_INT_CLEAR))
        stat_q <= (stat_q & ~HWDATA[`IRQ_WIDTH-1:0]) | ev;
      else
        stat_q <= stat_q | ev;
      IRQ <= |(stat_q & ien_q);
    end
  end
endmodule

// file: test/rtc_control_properties.sv
module rtc_control_properties (
  input wire        CLK_SYS,
  input wire        RST,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [31:0] HWDATA,
  input wire        HSEL,
  input wire        HREADY,
  input wire [31:0] HRDATA,
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire        OSC_ENABLE,
  input wire        IRQ
);
  wire tk = HSEL & HREADY & HTRANS[1];
  wire rd = tk & !HWRITE;
  wire wc = tk & HWRITE & (HADDR[7:0] == 8'h04);
  wire we = tk & HWRITE & (HADDR[7:0] == 8'h14);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  a_resp_okay: assert property (HRESP == 1'b0) else $error("error response");
  a_ready_high: assert property (HREADYOUT == 1'b1) else $error("wait state");
  a_reset_quiet: assert property ($fell(RST) |-> !IRQ && !OSC_ENABLE && HRDATA == 32'h0)
    else $error("outputs not quiet after reset");
  a_osc_on: assert property (wc ##1 HWDATA[7] |-> ##[1:3] OSC_ENABLE)
    else $error("oscillator not enabled");
  a_osc_off: assert property (wc ##1 !HWDATA[7] |-> ##[1:3] !OSC_ENABLE)
    else $error("oscillator not disabled");
  a_osc_stable: assert property ($changed(OSC_ENABLE) |-> $past(wc, 2) || $past(wc, 3))
    else $error("oscillator enable moved alone");
  a_rdata_held: assert property ($changed(HRDATA) |-> $past(rd) || $past(rd, 2))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd && HADDR[7:0] == 8'h00 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (we ##1 HWDATA[3:0] == 4'h0 |-> ##[1:3] !IRQ)
    else $error("masked interrupt still high");
endmodule

// file: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic        OSC_CLK_IN = 1'b0;
  logic        osc_on = 1'b0;
  logic [1:0]  ph = 2'h0;
  logic [31:0] r, v;
  wire  [31:0] HRDATA;
  wire         HREADYOUT, HRESP, OSC_ENABLE, IRQ;
  integer      n_errors = 0, checked = 0, cyc = 0, i;
  integer      m_cap = 0, m_alarm = 0, m_ien = 0;
  logic [31:0] exp_q[$];
  rtc_control #(.MCLK_TIMEOUT_CYC(8)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HSEL(1'b1),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .OSC_CLK_IN(OSC_CLK_IN), .OSC_ENABLE(OSC_ENABLE), .IRQ(IRQ));
  ////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop;
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    if (w && a == 8'h08) m_cap = d;
    if (w && a == 8'h0c) m_alarm = d;
    if (w && a == 8'h14) m_ien = d;
    if (w && a == 8'h04 && d[1]) exp_q.push_back(m_cap);
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task poll(input integer b);
    for (i = 0; i < 40; i++) begin
      xfer(1'b0, 8'h04, 32'h0);
      if (r[b] === 1'b0) i = 40;
    end
    chk({31'h0, r[b]}, 32'h0);
  endtask
  ////////////////////////////////////////
  // Oscillator edge every 3 cycles, well inside the shortened timeout
  always @(posedge CLK_SYS) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h2 && osc_on) OSC_CLK_IN <= ~OSC_CLK_IN;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial forever #50 CLK_SYS = ~CLK_SYS;
  initial begin
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    xfer(1'b0, 8'h04, 32'h0); chk(r, 32'h0);
    xfer(1'b0, 8'h00, 32'h0); chk(r, 32'h0);
    osc_on <= 1'b1;
    v = lfsr(32'h24);
    xfer(1'b1, 8'h08, v);
    xfer(1'b1, 8'h04, 32'h82);
    poll(1);
    xfer(1'b0, 8'h1c, 32'h0); chk(r, exp_q.pop_front());
    repeat (40) @(posedge CLK_SYS);
    xfer(1'b0, 8'h1c, 32'h0); chk(r, v);
    xfer(1'b1, 8'h04, 32'h81);
    poll(0);
    xfer(1'b0, 8'h08, 32'h0); chk(r, v);
    xfer(1'b1, 8'h04, 32'h90);
    repeat (60) @(posedge CLK_SYS);
    xfer(1'b0, 8'h1c, 32'h0); chk({31'h0, r == v}, 32'h0);
    xfer(1'b1, 8'h04, 32'h80);
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h04, 32'h82);
    poll(1);
    xfer(1'b0, 8'h1c, 32'h0); chk(r, exp_q.pop_front());
    xfer(1'b1, 8'h0c, lfsr(v));
    xfer(1'b0, 8'h0c, 32'h0); chk(r, m_alarm);
    xfer(1'b1, 8'h0c, 32'h5);
    xfer(1'b1, 8'h14, 32'h1);
    xfer(1'b0, 8'h14, 32'h0); chk(r, m_ien);
    xfer(1'b1, 8'h04, 32'h9c);
    for (i = 0; i < 300 && IRQ !== 1'b1; i++) @(posedge CLK_SYS);
    chk({31'h0, IRQ}, 32'h1);
    xfer(1'b0, 8'h10, 32'h0); chk({31'h0, r[0]}, 32'h1);
    repeat (8) begin
      repeat (5) @(posedge CLK_SYS);
      xfer(1'b0, 8'h1c, 32'h0); chk({31'h0, r > 7}, 32'h0);
    end
    xfer(1'b1, 8'h18, 32'h1);
    xfer(1'b1, 8'h14, 32'h0);
    repeat (4) @(posedge CLK_SYS);
    chk({31'h0, IRQ}, 32'h0);
    xfer(1'b1, 8'h04, 32'h94);
    xfer(1'b0, 8'h04, 32'h0); chk({31'h0, r[2]}, 32'h0);
    repeat (80) @(posedge CLK_SYS);
    xfer(1'b0, 8'h1c, 32'h0); chk({31'h0, r > 7}, 32'h1);
    // Stopped oscillator is the only way to provoke the detector
    osc_on <= 1'b0;
    xfer(1'b1, 8'h04, 32'hc0);
    repeat (40) @(posedge CLK_SYS);
    xfer(1'b0, 8'h04, 32'h0); chk({31'h0, r[5]}, 32'h1);
    xfer(1'b0, 8'h10, 32'h0); chk({31'h0, r[1]}, 32'h1);
    repeat (40) @(posedge CLK_SYS);
    xfer(1'b0, 8'h04, 32'h0); chk({31'h0, r[5]}, 32'h1);
    xfer(1'b1, 8'h04, 32'h80);
    xfer(1'b1, 8'h04, 32'h80);
    repeat (40) @(posedge CLK_SYS);
    xfer(1'b0, 8'h04, 32'h0); chk({31'h0, r[5]}, 32'h0);
    chk({31'h0, OSC_ENABLE}, 32'h1);
    xfer(1'b1, 8'h04, 32'h00);
    repeat (6) @(posedge CLK_SYS);
    chk({31'h0, OSC_ENABLE}, 32'h0);
    report_and_stop;
  end
endmodule
bind rtc_control rtc_control_properties chk_i (.CLK_SYS(CLK_SYS), .RST(RST), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HSEL(HSEL), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OSC_ENABLE(OSC_ENABLE),
  .IRQ(IRQ));
